/* hdl/uart_ctl2_pkg.sv */
package uart_ctl2_pkg;
  // ----------------------------------------
  // Register map (byte addresses, index times four)
  // ----------------------------------------
  localparam logic [7:0] CONTROL_TWO_IDX = 8'h03;
  localparam logic [7:0] CONTROL_TWO_ADDR = 8'h0C;
  localparam logic [7:0] LINK_CFG_ADDR = 8'h10;
  localparam logic [7:0] STATUS_ADDR = 8'h14;
  localparam logic [7:0] TX_DATA_ADDR = 8'h18;
  localparam logic [7:0] RX_DATA_ADDR = 8'h1C;
  // ----------------------------------------
  // control_two fields
  // ----------------------------------------
  localparam int TX_EMPTY_IRQ_EN_BIT = 7;
  localparam int TX_DONE_IRQ_EN_BIT = 6;
  localparam int RX_FULL_IRQ_EN_BIT = 5;
  localparam int LINE_IDLE_IRQ_EN_BIT = 4;
  localparam int TX_ENABLE_BIT = 3;
  localparam int RX_ENABLE_BIT = 2;
  localparam int RX_STANDBY_BIT = 1;
  localparam int BREAK_REQUEST_BIT = 0;
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
  // ----------------------------------------
  // link_cfg fields
  // ----------------------------------------
  localparam int LOOPBACK_SELECT_BIT = 0;
  localparam int RX_SOURCE_SELECT_BIT = 1;
  localparam int SINGLE_LINE_DIRECTION_BIT = 2;
  localparam int STANDBY_EXIT_METHOD_BIT = 3;
  localparam int LONG_BREAK_SELECT_BIT = 4;
  localparam logic [4:0] LINK_CFG_RESET = 5'h00;
  // ----------------------------------------
  // status fields
  // ----------------------------------------
  localparam int TX_BUFFER_EMPTY_BIT = 7;
  localparam int TX_DONE_FLAG_BIT = 6;
  localparam int RX_BUFFER_FULL_BIT = 5;
  localparam int LINE_IDLE_BIT = 4;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int BAUD = 9600;
  localparam logic [15:0] BIT_CYCLES = 16'(CLK_HZ / BAUD);
  localparam logic [15:0] HALF_BIT_CYCLES = 16'(CLK_HZ / BAUD / 2);
  localparam logic [3:0] CHAR_BITS = 4'hA;
  localparam logic [3:0] IDLE_BITS = 4'hA;
  localparam logic [3:0] BREAK_BITS = 4'hA;
  localparam logic [3:0] LONG_BREAK_BITS = 4'hD;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_DATA = 2'b01,
    TX_PREAMBLE = 2'b10,
    TX_BREAK = 2'b11
  } tx_state_t;
endpackage

/* hdl/uart_bit_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bit-time tick generator
// ----------------------------------------
module uart_bit_timer (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic restart,
  output logic tick
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 16'h0000;
    end else if (restart) begin
      // Start edge: first tick lands mid-bit
      cnt_q <= uart_ctl2_pkg::HALF_BIT_CYCLES;
    end else if (cnt_q == uart_ctl2_pkg::BIT_CYCLES - 16'h0001) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign tick = !restart && (cnt_q == uart_ctl2_pkg::BIT_CYCLES - 16'h0001);
endmodule // uart_bit_timer
`default_nettype wire

/* hdl/uart_control_two.sv */
// Summary of operation
// - tx_empty_irq_en set: request interrupt while tx_buffer_empty is 1.
// - tx_done_irq_en set: request interrupt while tx_done_flag is 1.
// - rx_full_irq_en set: request interrupt while rx_buffer_full is 1.
// - line_idle_irq_en set: request interrupt while line idle flag is 1.
// - Transmitter runs only with tx_enable; it then owns serial_out_pin (here break_request also sends breaks and takes the pin with tx_enable clear).
// - Single-wire mode: single_line_direction picks transmit or receive on shared pin.
// - Clearing then setting tx_enable during transmission queues one idle character.
// - After tx_enable cleared, keep pin until pending data, idle, break finish.
// - rx_enable low: receiver off, serial_in_pin released to port use.
// - loopback_select releases serial_in_pin even with rx_enable set.
// - Writing rx_standby 1 puts receiver in standby awaiting wakeup.
// - Wakeup is idle line, or msb 1 when standby_exit_method set.
// - Hardware clears rx_standby on the selected wakeup condition.
// - Writing break_request 1 then 0 queues one break character.
// - Breaks repeat while break_request held; 10 or 13 bit times long.
// - control_two readable and writable at any time.
// - Single-wire: serial_out_pin feeds both transmitter and receiver.
// - tx_buffer_empty set at reset and on buffer-to-shifter transfer.
// - tx_done_flag set at reset and when nothing is being sent.
// - rx_buffer_full set when received character enters receive register.
`timescale 1ns/1ps
`default_nettype none
module uart_control_two (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_out_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_n,
  output logic serial_out_pin_owned,
  input wire logic serial_in_pin,
  output logic serial_in_pin_owned,
  output logic irq
);
  logic [7:0] ctl_q;
  logic [4:0] cfg_q;
  logic [7:0] txbuf_q;
  logic txbuf_full_q;
  logic tx_done_q;
  logic [1:0] tx_state_q;
  logic [3:0] tx_bits_q;
  logic [9:0] tx_shift_q;
  logic idle_pend_q;
  logic brk_pend_q;
  logic tx_out_q;
  logic [7:0] rxbuf_q;
  logic rx_full_q;
  logic rx_busy_q;
  logic [3:0] rx_bits_q;
  logic [7:0] rx_shift_q;
  logic [3:0] idle_cnt_q;
  logic line_idle_q;
  logic rx_prev_q;
  logic tx_tick;
  logic rx_tick;
  logic rx_restart;
  logic wr;
  logic rd;
  logic loop_mode;
  logic single_wire;
  logic tx_drive;
  logic rx_line;
  logic rx_active;
  logic rx_done;
  logic [7:0] rx_char;
  logic tx_start_data;
  logic [3:0] brk_len;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pslverr = psel && penable && !(paddr == uart_ctl2_pkg::CONTROL_TWO_ADDR ||
    paddr == uart_ctl2_pkg::LINK_CFG_ADDR || paddr == uart_ctl2_pkg::STATUS_ADDR ||
    paddr == uart_ctl2_pkg::TX_DATA_ADDR || paddr == uart_ctl2_pkg::RX_DATA_ADDR);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        uart_ctl2_pkg::CONTROL_TWO_ADDR: prdata <= {24'h000000, ctl_q};
        uart_ctl2_pkg::LINK_CFG_ADDR: prdata <= {27'h0000000, cfg_q};
        uart_ctl2_pkg::STATUS_ADDR: prdata <= {24'h000000, !txbuf_full_q, tx_done_q,
          rx_full_q, line_idle_q, 4'h0};
        uart_ctl2_pkg::RX_DATA_ADDR: prdata <= {24'h000000, rxbuf_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= uart_ctl2_pkg::LINK_CFG_RESET;
    end else if (wr && paddr == uart_ctl2_pkg::LINK_CFG_ADDR) begin
      cfg_q <= pwdata[4:0];
    end
  end

  // hardware clears standby, wins over write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= uart_ctl2_pkg::CONTROL_TWO_RESET;
    end else begin
      if (wr && paddr == uart_ctl2_pkg::CONTROL_TWO_ADDR) begin
        ctl_q <= pwdata[7:0];
      end
      if (ctl_q[uart_ctl2_pkg::RX_STANDBY_BIT] &&
          (cfg_q[uart_ctl2_pkg::STANDBY_EXIT_METHOD_BIT] ? (rx_done && rx_char[7])
                                                          : (idle_cnt_q == uart_ctl2_pkg::IDLE_BITS
                                                             && rx_tick && !line_idle_q))) begin
        ctl_q[uart_ctl2_pkg::RX_STANDBY_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin ownership
  // ----------------------------------------
  assign loop_mode = cfg_q[uart_ctl2_pkg::LOOPBACK_SELECT_BIT];
  assign single_wire = loop_mode && cfg_q[uart_ctl2_pkg::RX_SOURCE_SELECT_BIT];
  assign tx_drive = ctl_q[uart_ctl2_pkg::TX_ENABLE_BIT] || tx_state_q != uart_ctl2_pkg::TX_IDLE
    || idle_pend_q || brk_pend_q || txbuf_full_q;
  assign serial_out_pin_owned = tx_drive;
  assign serial_out_pin_out = tx_out_q;
  assign serial_out_pin_oe_n = !(tx_drive &&
    (!single_wire || cfg_q[uart_ctl2_pkg::SINGLE_LINE_DIRECTION_BIT]));
  assign serial_in_pin_owned = ctl_q[uart_ctl2_pkg::RX_ENABLE_BIT] && !loop_mode;
  assign rx_line = single_wire ? (serial_out_pin_oe_n ? serial_out_pin_in : tx_out_q)
                 : (loop_mode ? tx_out_q : serial_in_pin);
  assign rx_active = ctl_q[uart_ctl2_pkg::RX_ENABLE_BIT];

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  uart_bit_timer u_tx_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .restart(1'b0),
    .tick(tx_tick)
  );

  assign brk_len = cfg_q[uart_ctl2_pkg::LONG_BREAK_SELECT_BIT] ? uart_ctl2_pkg::LONG_BREAK_BITS
                 : uart_ctl2_pkg::BREAK_BITS;
  assign tx_start_data = tx_tick && tx_state_q == uart_ctl2_pkg::TX_IDLE && !idle_pend_q &&
    !brk_pend_q && txbuf_full_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idle_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else begin
      if (tx_tick && tx_state_q == uart_ctl2_pkg::TX_IDLE) begin
        if (brk_pend_q) begin
          brk_pend_q <= 1'b0;
        end else if (idle_pend_q) begin
          idle_pend_q <= 1'b0;
        end
      end
      if (wr && paddr == uart_ctl2_pkg::CONTROL_TWO_ADDR) begin
        if (pwdata[uart_ctl2_pkg::TX_ENABLE_BIT] && !ctl_q[uart_ctl2_pkg::TX_ENABLE_BIT]) begin
          idle_pend_q <= 1'b1;
        end
        if (!pwdata[uart_ctl2_pkg::BREAK_REQUEST_BIT] &&
            ctl_q[uart_ctl2_pkg::BREAK_REQUEST_BIT]) begin
          brk_pend_q <= 1'b1;
        end
      end
      if (ctl_q[uart_ctl2_pkg::BREAK_REQUEST_BIT] && tx_tick &&
          tx_state_q == uart_ctl2_pkg::TX_IDLE && !brk_pend_q) begin
        brk_pend_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_state_q <= uart_ctl2_pkg::TX_IDLE;
      tx_bits_q <= 4'h0;
      tx_shift_q <= 10'h3FF;
      tx_out_q <= 1'b1;
    end else if (tx_tick) begin
      unique case (tx_state_q)
        uart_ctl2_pkg::TX_IDLE: begin
          tx_out_q <= 1'b1;
          if (brk_pend_q) begin
            tx_state_q <= uart_ctl2_pkg::TX_BREAK;
            tx_bits_q <= brk_len - 4'h1;
            tx_out_q <= 1'b0;
          end else if (idle_pend_q) begin
            tx_state_q <= uart_ctl2_pkg::TX_PREAMBLE;
            tx_bits_q <= uart_ctl2_pkg::IDLE_BITS - 4'h1;
          end else if (tx_start_data) begin
            tx_state_q <= uart_ctl2_pkg::TX_DATA;
            tx_bits_q <= uart_ctl2_pkg::CHAR_BITS - 4'h1;
            tx_shift_q <= {1'b1, 1'b1, txbuf_q};
            tx_out_q <= 1'b0;
          end
        end
        uart_ctl2_pkg::TX_DATA: begin
          tx_out_q <= tx_shift_q[0];
          tx_shift_q <= {1'b1, tx_shift_q[9:1]};
          tx_bits_q <= tx_bits_q - 4'h1;
          if (tx_bits_q == 4'h0) begin
            tx_state_q <= uart_ctl2_pkg::TX_IDLE;
            tx_out_q <= 1'b1;
          end
        end
        uart_ctl2_pkg::TX_PREAMBLE, uart_ctl2_pkg::TX_BREAK: begin
          tx_bits_q <= tx_bits_q - 4'h1;
          if (tx_bits_q == 4'h0) begin
            tx_state_q <= uart_ctl2_pkg::TX_IDLE;
            tx_out_q <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txbuf_full_q <= 1'b0;
      txbuf_q <= 8'h00;
    end else if (wr && paddr == uart_ctl2_pkg::TX_DATA_ADDR && tx_drive) begin
      txbuf_full_q <= 1'b1;
      txbuf_q <= pwdata[7:0];
    end else if (tx_start_data) begin
      txbuf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_done_q <= 1'b1;
    end else begin
      tx_done_q <= !txbuf_full_q && tx_state_q == uart_ctl2_pkg::TX_IDLE &&
        !idle_pend_q && !brk_pend_q;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  assign rx_restart = rx_active && !rx_busy_q && rx_prev_q && !rx_line;
  uart_bit_timer u_rx_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .restart(rx_restart),
    .tick(rx_tick)
  );
  assign rx_done = rx_tick && rx_busy_q && rx_bits_q == 4'h0;
  assign rx_char = rx_shift_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_prev_q <= 1'b1;
      rx_busy_q <= 1'b0;
      rx_bits_q <= 4'h0;
      rx_shift_q <= 8'h00;
    end else begin
      rx_prev_q <= rx_line;
      if (!rx_active) begin
        rx_busy_q <= 1'b0;
      end else if (rx_restart) begin
        rx_busy_q <= 1'b1;
        rx_bits_q <= uart_ctl2_pkg::CHAR_BITS - 4'h1;
      end else if (rx_tick && rx_busy_q) begin
        rx_bits_q <= rx_bits_q - 4'h1;
        if (rx_bits_q != uart_ctl2_pkg::CHAR_BITS - 4'h1 && rx_bits_q != 4'h0) begin
          rx_shift_q <= {rx_line, rx_shift_q[7:1]};
        end
        if (rx_bits_q == 4'h0) begin
          rx_busy_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_full_q <= 1'b0;
      rxbuf_q <= 8'h00;
    end else if (rx_done && !ctl_q[uart_ctl2_pkg::RX_STANDBY_BIT]) begin
      rx_full_q <= 1'b1;
      rxbuf_q <= rx_char;
    end else if (rd && paddr == uart_ctl2_pkg::RX_DATA_ADDR) begin
      rx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idle_cnt_q <= 4'h0;
      line_idle_q <= 1'b0;
    end else if (!rx_active || rx_busy_q || !rx_line) begin
      idle_cnt_q <= 4'h0;
      line_idle_q <= 1'b0;
    end else if (rx_tick && idle_cnt_q != uart_ctl2_pkg::IDLE_BITS) begin
      idle_cnt_q <= idle_cnt_q + 4'h1;
    end else if (rx_tick) begin
      line_idle_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  // masked sources combined
  assign irq = (ctl_q[uart_ctl2_pkg::TX_EMPTY_IRQ_EN_BIT] && !txbuf_full_q) ||
               (ctl_q[uart_ctl2_pkg::TX_DONE_IRQ_EN_BIT] && tx_done_q) ||
               (ctl_q[uart_ctl2_pkg::RX_FULL_IRQ_EN_BIT] && rx_full_q) ||
               (ctl_q[uart_ctl2_pkg::LINE_IDLE_IRQ_EN_BIT] && line_idle_q);
endmodule // uart_control_two
`default_nettype wire

/* testbench/uart_control_two_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_control_two_sva (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_out_pin_in,
  input wire logic serial_out_pin_out,
  input wire logic serial_out_pin_oe_n,
  input wire logic serial_out_pin_owned,
  input wire logic serial_in_pin,
  input wire logic serial_in_pin_owned,
  input wire logic irq
);
  logic [7:0] ctl_q;
  logic [4:0] cfg_q;
  logic acc, hit, rx_ok, tx_en;
  assign acc = psel && penable;
  assign hit = paddr inside {8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  assign rx_ok = ctl_q[2] && !cfg_q[0];
  assign tx_en = ctl_q[3];
  // ----------------------------------------
  // Shadows of the written registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= 8'h00;
      cfg_q <= 5'h00;
    end else if (acc && pwrite && paddr == 8'h0C) begin
      ctl_q <= pwdata[7:0];
    end else if (acc && pwrite && paddr == 8'h10) begin
      cfg_q <= pwdata[4:0];
    end
  end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  a_ready_now: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_bad_addr: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_ctl_read: assert property (acc && !pwrite && paddr == 8'h0C |-> prdata[31:8] == 24'h0
    && prdata[7:2] == ctl_q[7:2] && prdata[0] == ctl_q[0])
    else $error("control_two read differs");
  a_irq_masked: assert property (ctl_q[7:4] == 4'h0 |-> !irq)
    else $error("irq with all sources masked");
  a_rx_pin: assert property ($stable(rx_ok) |-> serial_in_pin_owned == rx_ok)
    else $error("rx pin ownership wrong");
  a_oe_owned: assert property (!serial_out_pin_oe_n |-> serial_out_pin_owned)
    else $error("tx pin driven while released");
  a_tx_start: assert property ($rose(serial_out_pin_owned) |-> tx_en || $past(tx_en))
    else $error("tx pin taken without tx_enable");
  a_wire_rx: assert property (cfg_q[2:0] == 3'b011 && $stable(cfg_q)
    |-> serial_out_pin_oe_n)
    else $error("single wire receive drives pin");
  a_good_addr: assert property (acc && hit |-> !pslverr)
    else $error("mapped access refused");
endmodule // uart_control_two_sva
bind uart_control_two uart_control_two_sva sva_i (.clk_sys(clk_sys), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_out_pin_in(serial_out_pin_in),
  .serial_out_pin_out(serial_out_pin_out), .serial_out_pin_oe_n(serial_out_pin_oe_n),
  .serial_out_pin_owned(serial_out_pin_owned), .serial_in_pin(serial_in_pin),
  .serial_in_pin_owned(serial_in_pin_owned), .irq(irq));
`default_nettype wire

/* testbench/uart_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_peer #(
  parameter int BIT = 1041
) (
  input wire logic clk_sys,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] sh;
  int run_c = 0;
  int low_run = 0;
  initial line_out = 1'b1;
  task automatic send_char(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge clk_sys);
    end
  endtask
  // length of the last low stretch
  always @(posedge clk_sys) begin
    if (!line_in) begin
      run_c <= run_c + 1;
    end else begin
      if (run_c != 0) low_run <= run_c;
      run_c <= 0;
    end
  end
  // Mid-bit sampling of frames from the device
  initial forever begin
    @(posedge clk_sys iff line_in === 1'b0);
    repeat (BIT + BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      sh[i] = line_in;
      repeat (BIT) @(posedge clk_sys);
    end
    rx_byte = sh;
    @(posedge clk_sys iff line_in === 1'b1);
  end
endmodule // uart_peer
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int BIT = int'(uart_ctl2_pkg::BIT_CYCLES);
  localparam logic [7:0] CTL = uart_ctl2_pkg::CONTROL_TWO_ADDR;
  localparam logic [7:0] CFG = uart_ctl2_pkg::LINK_CFG_ADDR;
  localparam logic [7:0] STA = uart_ctl2_pkg::STATUS_ADDR;
  localparam logic [7:0] RXD = uart_ctl2_pkg::RX_DATA_ADDR;
  logic clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, st;
  logic pready, pslverr, slv, so_out, so_oe_n, so_owned, si_pin, si_owned, irq, line;
  int err_total = 0, cmp_count = 0, n;
  always #50 clk_sys = ~clk_sys;
  // Tx line has a pull-up when released
  assign line = so_oe_n ? 1'b1 : so_out;
  uart_control_two DUT (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_out_pin_in(line), .serial_out_pin_out(so_out),
    .serial_out_pin_oe_n(so_oe_n), .serial_out_pin_owned(so_owned), .serial_in_pin(si_pin),
    .serial_in_pin_owned(si_owned), .irq(irq));
  uart_peer #(.BIT(BIT)) peer (.clk_sys(clk_sys), .line_in(line), .line_out(si_pin));
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic wait_free(input int lim);
    n = 0;
    while (so_owned !== 1'b0 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk("tx_pin_release", 32'h0, {31'h0, so_owned});
  endtask
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (98000) @(posedge clk_sys);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, CTL, 32'h0);
    chk("ctl_reset", 32'h0, rd);
    apb(1'b0, STA, 32'h0);
    chk("tx_flags_reset", 32'hC0, rd & 32'hE0);
    apb(1'b0, 8'h04, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, slv});
    for (int b = 4; b < 8; b++) begin
      apb(1'b0, STA, 32'h0);
      st = rd;
      apb(1'b1, CTL, 32'h1 << b);
      chk("irq_source", {31'h0, st[b]}, {31'h0, irq});
      apb(1'b0, CTL, 32'h0);
      chk("ctl_readback", 32'h1 << b, rd);
    end
    apb(1'b1, CTL, 32'h04);
    chk("rx_pin_taken", 32'h1, {31'h0, si_owned});
    apb(1'b1, CFG, 32'h01);
    chk("rx_pin_loop", 32'h0, {31'h0, si_owned});
    apb(1'b1, CFG, 32'h00);
    apb(1'b1, CTL, 32'h08);
    chk("tx_pin_drive", 32'h1, {31'h0, so_owned & ~so_oe_n});
    apb(1'b1, CFG, 32'h03);
    chk("single_rx_dir", 32'h1, {31'h0, so_oe_n});
    apb(1'b1, CFG, 32'h07);
    chk("single_tx_dir", 32'h0, {31'h0, so_oe_n});
    apb(1'b1, CFG, 32'h00);
    apb(1'b1, uart_ctl2_pkg::TX_DATA_ADDR, 32'h5A);
    apb(1'b1, CTL, 32'h00);
    chk("tx_pin_held", 32'h1, {31'h0, so_owned});
    wait_free(25 * BIT);
    chk("tx_char", 32'h5A, {24'h0, peer.rx_byte});
    for (int lb = 0; lb < 2; lb++) begin
      apb(1'b1, CFG, lb ? 32'h10 : 32'h00);
      apb(1'b1, CTL, 32'h09);
      apb(1'b1, CTL, 32'h08);
      repeat ((22 + 3 * lb) * BIT) @(posedge clk_sys);
      n = (10 + 3 * lb) * BIT;
      chk("break_len", 32'h1, {31'h0, peer.low_run >= n - 2 && peer.low_run <= n + 2});
      apb(1'b1, CTL, 32'h00);
      wait_free(4 * BIT);
    end
    apb(1'b1, CFG, 32'h08);
    apb(1'b1, CTL, 32'h26);
    peer.send_char(8'h81);
    repeat (2) @(posedge clk_sys);
    apb(1'b0, CTL, 32'h0);
    chk("standby_exit", 32'h24, rd);
    apb(1'b0, RXD, 32'h0);
    peer.send_char(8'h3C);
    repeat (2) @(posedge clk_sys);
    chk("rx_irq", 32'h1, {31'h0, irq});
    apb(1'b0, STA, 32'h0);
    chk("rx_full", 32'h20, rd & 32'h20);
    apb(1'b0, RXD, 32'h0);
    chk("rx_char", 32'h3C, rd);
    chk("rx_irq_clear", 32'h0, {31'h0, irq});
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
